// *** design/watchdog_down_counter.sv ***
// watchdog down counter with pending-flag reset and standby wake-up
`timescale 1ns/1ns
`default_nettype none
`include "wdt_cfg.svh"
module watchdog_down_counter
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // low-speed counting clock pin, 32.768 kHz
   input  wire logic              i_lsclk,
   // software control
   input  wire logic              i_enable,
   input  wire logic              i_reset_enable,
   input  wire wdt_pkg::count_type i_reload_value,
   input  wire logic              i_reload_req,
   input  wire logic              i_clear_req,
   // system state
   input  wire logic              i_standby,
   // status and events
   output logic                   o_irq,
   output logic                   o_status,
   output logic                   o_wakeup,
   output logic                   o_sys_reset,
   output wdt_pkg::count_type     o_count
);
   import wdt_pkg::*;

   tick_if    tick_bus ();
   state_type state;
   state_type next_state;
   count_type count;
   count_type next_count;
   logic      status;
   logic      wakeup;
   logic [`WDT_RST_WIDTH-1:0] rst_cnt;

   wire running;
   wire at_zero;
   wire expire;
   wire rearm;

   // [RQ1] pin sampled and edge detected
   lsclk_tick u_tick
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_lsclk (i_lsclk),
      .o_tick  (tick_bus)
   );

   assign running = (state == st_run);
   assign at_zero = (count == `WDT_COUNT_ZERO);
   // [RQ2] zero reached on a counting tick
   assign expire  = running & tick_bus.tick & at_zero;
   // [RQ4] second expiry with flag still pending
   assign rearm   = expire & status & i_reset_enable;

   // [RQ7] run only while enabled
   always_comb
   begin
      next_state = state;
      case (state)
         st_idle: if (i_enable) next_state = st_run;
         st_run:  if (!i_enable) next_state = st_idle;
         default: next_state = st_idle;
      endcase
   end

   always_comb
   begin
      next_count = count;
      if (state == st_idle && i_enable)
         next_count = i_reload_value;
      // [RQ6] software reload restarts interval
      else if (running && i_reload_req)
         next_count = i_reload_value;
      // [RQ3] reload on zero
      else if (expire)
         next_count = i_reload_value;
      // [RQ1] one step per tick
      else if (running && tick_bus.tick)
         next_count = count - `WDT_COUNT_STEP;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state <= st_idle;
         count <= `WDT_COUNT_RESET;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
      end
   end

   // set beats clear in the same cycle so no expiry is lost
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         status <= 1'b0;
      // [RQ5] held until cleared
      else if (expire)
         status <= 1'b1;
      // [RQ9] software clear
      else if (i_clear_req)
         status <= 1'b0;
   end

   // reset held a fixed width so the system sees it regardless of its own clocking
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         rst_cnt <= `WDT_RST_NONE;
      // [RQ4] start the reset pulse
      else if (rearm)
         rst_cnt <= `WDT_RST_PULSE;
      else if (rst_cnt != `WDT_RST_NONE)
         rst_cnt <= rst_cnt - `WDT_RST_ONE;
   end

   // [RQ8] interrupt wakes from standby
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         wakeup <= 1'b0;
      else
         wakeup <= i_standby & (status | expire);
   end

   assign o_status    = status;
   assign o_irq       = status;
   assign o_wakeup    = wakeup;
   assign o_sys_reset = (rst_cnt != `WDT_RST_NONE);
   assign o_count     = count;
endmodule
`default_nettype wire

// *** pkg/wdt_cfg.svh ***
// constants for the watchdog down counter
// How it works
// [RQ1] 32-bit counter decrements once per 32.768 kHz input clock cycle.
// [RQ2] reaching zero sets the interrupt status flag and raises the interrupt.
// [RQ3] on zero the counter reloads from reload_value and keeps counting.
// [RQ4] zero while status is still pending may assert system reset.
// [RQ5] interrupt stays pending until software clears the status flag.
// [RQ6] software reload request reloads counter, restarting the full interval.
// [RQ7] counter runs only after software enables the watchdog.
// [RQ8] counting continues in standby; interrupt wakes the system.
// [RQ9] software clear drops status, interrupt and the reset arming.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_COUNT_WIDTH   32
`define WDT_COUNT_RESET   32'hffffffff
`define WDT_COUNT_ZERO    32'h00000000
`define WDT_COUNT_STEP    32'h00000001
`define WDT_LSCLK_HZ      32768
`define WDT_SYS_HZ        10000000
`define WDT_RST_WIDTH     8
`define WDT_RST_PULSE     8'h10
`define WDT_RST_ONE       8'h01
`define WDT_RST_NONE      8'h00
`endif

// *** pkg/wdt_pkg.sv ***
// types shared by the watchdog modules
`include "wdt_cfg.svh"
package wdt_pkg;
   typedef logic [`WDT_COUNT_WIDTH-1:0] count_type;
   typedef enum logic [1:0]
   {
      st_idle = 2'b01,
      st_run  = 2'b10
   } state_type;
endpackage

// *** pkg/tick_if.sv ***
// carries the low-speed tick from the synchroniser to the counter
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
   logic tick;
   modport src (output tick);
   modport snk (input tick);
endinterface
`default_nettype wire

// *** design/lsclk_tick.sv ***
// synchronises the low-speed clock pin and emits one tick per rising edge
`timescale 1ns/1ns
`default_nettype none
module lsclk_tick
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // low-speed clock pin
   input  wire logic i_lsclk,
   // tick out
   tick_if.src       o_tick
);
   logic sync_a;
   logic sync_b;
   logic prev;
   wire  rise;

   // second stage and its delayed copy prev feed the edge detector
   assign rise = sync_b & ~prev;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev   <= 1'b0;
         o_tick.tick <= 1'b0;
      end
      else
      begin
         sync_a <= i_lsclk;
         sync_b <= sync_a;
         prev   <= sync_b;
         o_tick.tick <= rise;
      end
   end
endmodule
`default_nettype wire

// *** verif/watchdog_monitor.sv ***
// port assertions for the watchdog down counter
`timescale 1ns/1ns
`default_nettype none
module watchdog_monitor
(
   // clock and reset
   input wire logic               i_clk,
   input wire logic               i_rst,
   // control
   input wire logic               i_enable,
   input wire logic               i_reset_enable,
   input wire wdt_pkg::count_type i_reload_value,
   input wire logic               i_reload_req,
   input wire logic               i_clear_req,
   // outputs
   input wire logic               o_irq,
   input wire logic               o_status,
   input wire logic               o_sys_reset,
   input wire wdt_pkg::count_type o_count
);
   import wdt_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   irq_follow_a: assert property (o_irq == o_status)
      else $error("irq off");
   count_step_a: assert property ($past(i_enable, 2) && $past(i_enable)
      && !$past(i_reload_req) && $past(o_count) != 0 && $changed(o_count)
      |-> o_count == $past(o_count) - 1) else $error("bad step");
   idle_hold_a: assert property (!$past(i_enable, 2) && !$past(i_enable)
      && !$past(i_rst) |-> $stable(o_count)) else $error("idle count moved");
   reload_take_a: assert property (i_reload_req && i_enable
      |=> o_count == $past(i_reload_value)) else $error("no reload");
   expiry_load_a: assert property ($rose(o_status)
      |-> $past(o_count) == 0 && o_count == $past(i_reload_value)) else $error("bad expiry");
   clear_drop_a: assert property (i_clear_req && o_count != 0 |=> !o_status)
      else $error("clear lost");
   status_hold_a: assert property (o_status && !i_clear_req |=> o_status)
      else $error("status lost");
   reset_fire_a: assert property (o_status && $past(o_status) && $past(o_count) == 0
      && o_count != 0 && $past(i_reset_enable) && !$past(i_reload_req)
      |-> ##[0:1] o_sys_reset) else $error("no reset");
endmodule
bind watchdog_down_counter watchdog_monitor watchdog_monitor_inst (.*);
`default_nettype wire

// *** verif/tb_watchdog_down_counter.sv ***
// bench for the watchdog down counter
`timescale 1ns/1ns
`default_nettype none
module tb_watchdog_down_counter;
   import wdt_pkg::*;
   logic      i_clk, i_rst, i_lsclk, i_enable, i_reset_enable;
   logic      i_reload_req, i_clear_req, i_standby;
   logic      o_irq, o_status, o_wakeup, o_sys_reset;
   count_type i_reload_value, o_count;
   int        errors, n_checks, i;
   watchdog_down_counter watchdog_down_counter_inst (.*);
   initial
   begin
      i_clk = 0;
      forever #50 i_clk = ~i_clk;
   end
   // low-speed clock, not phase related to i_clk
   initial
   begin
      i_lsclk = 0;
      forever #15259 i_lsclk = ~i_lsclk;
   end
   task cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task chk(input count_type got, input count_type exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task complete_run;
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task t_idle;
      cyc(700);
      chk(o_count, 32'hffffffff);
      $display("t_idle done");
   endtask
   task t_expire;
      i_reset_enable = 1;
      i_enable = 1;
      for (i = 0; i < 3000 && o_status !== 1'b1; i++) cyc(1);
      chk(o_count, 32'h00000003);
      chk(o_irq, 1'b1);
      i_standby = 1;
      cyc(2);
      chk(o_wakeup, 1'b1);
      // pending flag left set, so the next zero must reset
      for (i = 0; i < 3000 && o_sys_reset !== 1'b1; i++) cyc(1);
      chk(o_sys_reset, 1'b1);
      chk(o_status, 1'b1);
      $display("t_expire done");
   endtask
   task t_reload;
      i_standby = 0;
      i_clear_req = 1;
      cyc(1);
      i_clear_req = 0;
      chk(o_status, 1'b0);
      i_reload_value = 32'h00000010;
      i_reload_req = 1;
      cyc(1);
      i_reload_req = 0;
      chk(o_count, 32'h00000010);
      for (i = 0; i < 1000 && o_count === 32'h00000010; i++) cyc(1);
      chk(o_count, 32'h0000000f);
      $display("t_reload done");
   endtask
   initial
   begin
      #2000000;
      errors++;
      complete_run;
   end
   initial
   begin
      i_rst = 1;
      {i_enable, i_reset_enable, i_reload_req, i_clear_req, i_standby} = 5'h00;
      i_reload_value = 32'h00000003;
      cyc(12);
      i_rst = 0;
      t_idle;
      t_expire;
      t_reload;
      complete_run;
   end
endmodule
`default_nettype wire
